// ==== prio_pkg.sv ====
// shared constants and types for the interrupt priority level bank
package prio_pkg;
    // ********************
    // bus and register map
    // ********************
    localparam int ADDR_W = 28;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_LINE_LOW   = 28'h5FFFF84;
    localparam logic [ADDR_W-1:0] OFS_LINE_HIGH  = 28'h5FFFF86;
    localparam logic [ADDR_W-1:0] OFS_DMA_TIMER  = 28'h5FFFF88;
    localparam logic [ADDR_W-1:0] OFS_TIMER_SER  = 28'h5FFFF8A;
    localparam logic [ADDR_W-1:0] OFS_SER_BUS_WD = 28'h5FFFF8C;
    localparam logic [DATA_W-1:0] RST_LEVELS     = 16'h0000;
    localparam logic [DATA_W-1:0] RD_IDLE        = 16'h0000;

    // ********************
    // level fields
    // ********************
    localparam int LVL_W   = 4;
    localparam int NIB_TOP = 3;
    localparam int NIB_HI  = 2;
    localparam int NIB_LO  = 1;
    localparam int NIB_BOT = 0;
    localparam logic [LVL_W-1:0] LVL_MASKED = 4'h0;

    // ********************
    // request sources
    // ********************
    localparam int NUM_EXT = 8;
    localparam int NUM_DMA = 4;
    localparam int NUM_TMR = 5;
    localparam int NUM_SER = 2;
    localparam int NUM_SRC = 23;
    localparam int SRC_W   = 5;
    localparam int SRC_DMA = 8;
    localparam int SRC_TMR = 12;
    localparam int SRC_SER = 17;
    localparam int SRC_PAR = 19;
    localparam int SRC_ADC = 20;
    localparam int SRC_WDT = 21;
    localparam int SRC_REF = 22;
    localparam logic [SRC_W-1:0] SRC_NONE = 5'h00;
    localparam logic [NUM_EXT-1:0] PIN_IDLE = 8'hFF;

    typedef struct packed {
        logic [DATA_W-1:0] line_low;
        logic [DATA_W-1:0] line_high;
        logic [DATA_W-1:0] dma_timer;
        logic [DATA_W-1:0] timer_serial;
        logic [DATA_W-1:0] serial_bus_wd;
    } level_regs_t;
endpackage

// ==== level_sync.sv ====
// two-flop synchroniser for the external request pins
`timescale 1ns/1ps
module level_sync (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [prio_pkg::NUM_EXT-1:0] pin_n,
    output logic      [prio_pkg::NUM_EXT-1:0] sync_n
);
    import prio_pkg::*;

    typedef struct packed {
        logic [NUM_EXT-1:0] stage1;
        logic [NUM_EXT-1:0] stage2;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = pin_n;
        state_next.stage2 = state_reg.stage1;
    end

    // idle-high reset so no line looks pending while reset lifts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= {PIN_IDLE, PIN_IDLE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_n = state_reg.stage2;

    property p_two_stage;
        @(posedge core_clk) disable iff (rst)
        !rst |-> ##2 (sync_n == $past(pin_n, 2));
    endproperty
    a_two_stage: assert property (p_two_stage)
        else $error("synchroniser output is not the pin two cycles back");
endmodule

// ==== level_pick.sv ====
// picks the pending source with the highest nonzero level
`timescale 1ns/1ps
module level_pick (
    input  wire logic                                        core_clk,
    input  wire logic                                        rst,
    input  wire logic [prio_pkg::NUM_SRC-1:0]                 pending,
    input  wire logic [prio_pkg::NUM_SRC*prio_pkg::LVL_W-1:0] levels,
    output logic                                             irq_req,
    output logic      [prio_pkg::LVL_W-1:0]                  irq_level,
    output logic      [prio_pkg::SRC_W-1:0]                  irq_source
);
    import prio_pkg::*;

    typedef struct packed {
        logic             req;
        logic [LVL_W-1:0] level;
        logic [SRC_W-1:0] source;
    } pick_state_t;

    pick_state_t state_reg;
    pick_state_t state_next;

    // strict compare: on a tie the lower source number keeps the slot
    always_comb begin
        logic [LVL_W-1:0] cand;
        cand       = LVL_MASKED;
        state_next = '{req: 1'b0, level: LVL_MASKED, source: SRC_NONE};
        for (int i = 0; i < NUM_SRC; i++) begin
            cand = levels[i*LVL_W +: LVL_W];
            if (pending[i] && cand > state_next.level) begin
                state_next.req    = 1'b1;
                state_next.level  = cand;
                state_next.source = SRC_W'(i);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{req: 1'b0, level: LVL_MASKED, source: SRC_NONE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign irq_req    = state_reg.req;
    assign irq_level  = state_reg.level;
    assign irq_source = state_reg.source;

    property p_masked_never_wins;
        @(posedge core_clk) disable iff (rst)
        irq_req |-> (irq_level != LVL_MASKED
                     && |(($past(pending) >> irq_source) & NUM_SRC'(1))
                     && LVL_W'($past(levels) >> (irq_source * LVL_W)) == irq_level);
    endproperty
    a_masked_never_wins: assert property (p_masked_never_wins)
        else $error("forwarded source was not pending at the forwarded level");

    property p_none_pending;
        @(posedge core_clk) disable iff (rst)
        (state_next.req == 1'b0) |=> !irq_req && irq_level == LVL_MASKED;
    endproperty
    a_none_pending: assert property (p_none_pending)
        else $error("request forwarded with nothing pending and unmasked");
endmodule

// ==== interrupt_priority_levels.sv ====
// priority level register bank and highest-level request selection
`timescale 1ns/1ps
module interrupt_priority_levels (
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    input  wire logic [prio_pkg::ADDR_W-1:0]  addr,
    input  wire logic [prio_pkg::DATA_W-1:0]  wr_data,
    input  wire logic                         wr_en,
    input  wire logic                         rd_en,
    output logic      [prio_pkg::DATA_W-1:0]  rd_data,
    input  wire logic [prio_pkg::NUM_EXT-1:0] irq_pin_n,
    input  wire logic [prio_pkg::NUM_DMA-1:0] dma_req,
    input  wire logic [prio_pkg::NUM_TMR-1:0] timer_req,
    input  wire logic [prio_pkg::NUM_SER-1:0] serial_req,
    input  wire logic                         parity_req,
    input  wire logic                         adc_req,
    input  wire logic                         watchdog_req,
    input  wire logic                         refresh_req,
    output logic                              irq_req,
    output logic      [prio_pkg::LVL_W-1:0]   irq_level,
    output logic      [prio_pkg::SRC_W-1:0]   irq_source
);
    import prio_pkg::*;

    typedef struct packed {
        level_regs_t       regs;
        logic [DATA_W-1:0] rd_data;
    } bank_state_t;

    bank_state_t                  state_reg;
    bank_state_t                  state_next;
    logic [NUM_EXT-1:0]           irq_sync_n;
    logic [NUM_SRC-1:0]           pending;
    logic [NUM_SRC*LVL_W-1:0]     levels;

    // ********************
    // field decoding
    // ********************
    function automatic logic [LVL_W-1:0] nib(input logic [DATA_W-1:0] r, input int n);
        return r[n*LVL_W +: LVL_W];
    endfunction

    function automatic logic [LVL_W-1:0] level_of(input level_regs_t r, input int s);
        logic [LVL_W-1:0] v;
        v = LVL_MASKED;
        if (s < 4) begin
            v = nib(r.line_low, NIB_TOP - s);
        end else if (s < SRC_DMA) begin
            v = nib(r.line_high, NIB_TOP - (s - 4));
        end else if (s < SRC_DMA + 2) begin
            v = nib(r.dma_timer, NIB_TOP);
        end else if (s < SRC_TMR) begin
            v = nib(r.dma_timer, NIB_HI);
        end else if (s < SRC_TMR + 2) begin
            v = nib(r.dma_timer, NIB_LO - (s - SRC_TMR));
        end else if (s < SRC_SER + 1) begin
            v = nib(r.timer_serial, NIB_TOP - (s - SRC_TMR - 2));
        end else if (s == SRC_SER + 1) begin
            v = nib(r.serial_bus_wd, NIB_TOP);
        end else if (s == SRC_PAR || s == SRC_ADC) begin
            v = nib(r.serial_bus_wd, NIB_HI);
        end else if (s == SRC_WDT || s == SRC_REF) begin
            v = nib(r.serial_bus_wd, NIB_LO);
        end
        return v;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // true when some pending source sits strictly above the given level
    function automatic logic any_above(input logic [NUM_SRC-1:0]       p,
                                       input logic [NUM_SRC*LVL_W-1:0] l,
                                       input logic [LVL_W-1:0]         ref_lvl);
        logic found;
        found = 1'b0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (p[s] && l[s*LVL_W +: LVL_W] > ref_lvl) begin
                found = 1'b1;
            end
        end
        return found;
    endfunction

    // ********************
    // request side
    // ********************
    level_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_n    (irq_pin_n),
        .sync_n   (irq_sync_n)
    );

    // on-chip requests share core_clk, so only the pins are synchronised
    assign pending = {refresh_req, watchdog_req, adc_req, parity_req,
                      serial_req, timer_req, dma_req, ~irq_sync_n};

    always_comb begin
        levels = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            levels[s*LVL_W +: LVL_W] = level_of(state_reg.regs, s);
        end
    end

    level_pick u_pick (
        .core_clk   (core_clk),
        .rst        (rst),
        .pending    (pending),
        .levels     (levels),
        .irq_req    (irq_req),
        .irq_level  (irq_level),
        .irq_source (irq_source)
    );

    // ********************
    // register bank
    // ********************
    // unmapped reads answer zero; unmapped writes are dropped
    always_comb begin
        state_next         = state_reg;
        state_next.rd_data = RD_IDLE;
        if (wr_en) begin
            if (hit(addr, OFS_LINE_LOW))   state_next.regs.line_low      = wr_data;
            if (hit(addr, OFS_LINE_HIGH))  state_next.regs.line_high     = wr_data;
            if (hit(addr, OFS_DMA_TIMER))  state_next.regs.dma_timer     = wr_data;
            if (hit(addr, OFS_TIMER_SER))  state_next.regs.timer_serial  = wr_data;
            if (hit(addr, OFS_SER_BUS_WD)) state_next.regs.serial_bus_wd = wr_data;
        end
        if (rd_en) begin
            if (hit(addr, OFS_LINE_LOW))   state_next.rd_data = state_reg.regs.line_low;
            if (hit(addr, OFS_LINE_HIGH))  state_next.rd_data = state_reg.regs.line_high;
            if (hit(addr, OFS_DMA_TIMER))  state_next.rd_data = state_reg.regs.dma_timer;
            if (hit(addr, OFS_TIMER_SER))  state_next.rd_data = state_reg.regs.timer_serial;
            if (hit(addr, OFS_SER_BUS_WD)) state_next.rd_data = state_reg.regs.serial_bus_wd;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{regs: '{RST_LEVELS, RST_LEVELS, RST_LEVELS, RST_LEVELS,
                                   RST_LEVELS}, rd_data: RD_IDLE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.rd_data;

    // ********************
    // checks
    // ********************
    sequence s_write(logic [ADDR_W-1:0] ofs);
        wr_en && addr == ofs;
    endsequence

    sequence s_read_back(logic [ADDR_W-1:0] ofs);
        ##1 rd_en && addr == ofs ##1 rd_data == $past(wr_data, 2);
    endsequence

    property p_ext_low_top;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_LINE_LOW) |=> levels[3:0] == $past(wr_data[15:12])
                                 && levels[15:12] == $past(wr_data[3:0]);
    endproperty
    a_ext_low_top: assert property (p_ext_low_top)
        else $error("external line 0 or 3 level not taken from its nibble");

    property p_ext_low_mid;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_LINE_LOW) |=> levels[7:4] == $past(wr_data[11:8])
                                 && levels[11:8] == $past(wr_data[7:4]);
    endproperty
    a_ext_low_mid: assert property (p_ext_low_mid)
        else $error("external line 1 or 2 level not taken from its nibble");

    property p_ext_high;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_LINE_HIGH) |=> levels[19:16] == $past(wr_data[15:12])
                                  && levels[31:28] == $past(wr_data[3:0]);
    endproperty
    a_ext_high: assert property (p_ext_high)
        else $error("external line 4 or 7 level misplaced");

    property p_ext_high_mid;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_LINE_HIGH) |=> levels[23:20] == $past(wr_data[11:8])
                                  && levels[27:24] == $past(wr_data[7:4]);
    endproperty
    a_ext_high_mid: assert property (p_ext_high_mid)
        else $error("external line 5 or 6 level misplaced");

    property p_dma_shared;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_DMA_TIMER) |=> levels[35:32] == levels[39:36]
                                  && levels[43:40] == levels[47:44]
                                  && levels[35:32] == $past(wr_data[15:12]);
    endproperty
    a_dma_shared: assert property (p_dma_shared)
        else $error("dma channel pairs do not share their level");

    property p_dma23;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_DMA_TIMER) |=> levels[43:40] == $past(wr_data[11:8]);
    endproperty
    a_dma23: assert property (p_dma23)
        else $error("dma channels 2 and 3 not taken from bits 11-8");

    property p_timer01;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_DMA_TIMER) |=> levels[51:48] == $past(wr_data[7:4])
                                  && levels[55:52] == $past(wr_data[3:0]);
    endproperty
    a_timer01: assert property (p_timer01)
        else $error("timer unit 0 or 1 level misplaced");

    property p_timer_serial;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_TIMER_SER) |=> levels[59:56] == $past(wr_data[15:12])
                                  && levels[71:68] == $past(wr_data[3:0]);
    endproperty
    a_timer_serial: assert property (p_timer_serial)
        else $error("timer unit 2 or serial channel 0 level misplaced");

    property p_timer34;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_TIMER_SER) |=> levels[63:60] == $past(wr_data[11:8])
                                  && levels[67:64] == $past(wr_data[7:4]);
    endproperty
    a_timer34: assert property (p_timer34)
        else $error("timer unit 3 or 4 level misplaced");

    // the forwarded level is never beaten by a pending source one cycle back
    property p_highest_wins;
        @(posedge core_clk) disable iff (rst)
        !any_above($past(pending), $past(levels), irq_level);
    endproperty
    a_highest_wins: assert property (p_highest_wins)
        else $error("a pending source with a higher level was passed over");

    property p_serial1;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_SER_BUS_WD) |=> levels[75:72] == $past(wr_data[15:12]);
    endproperty
    a_serial1: assert property (p_serial1)
        else $error("serial channel 1 level misplaced");

    property p_parity_adc;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_SER_BUS_WD) |=> levels[79:76] == $past(wr_data[11:8])
                                   && levels[83:80] == levels[79:76];
    endproperty
    a_parity_adc: assert property (p_parity_adc)
        else $error("parity check and a/d do not share bits 11-8");

    property p_wdt_refresh;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_SER_BUS_WD) |=> levels[87:84] == $past(wr_data[7:4])
                                   && levels[91:88] == levels[87:84];
    endproperty
    a_wdt_refresh: assert property (p_wdt_refresh)
        else $error("watchdog and refresh do not share bits 7-4");

    property p_read_back;
        @(posedge core_clk) disable iff (rst)
        s_write(OFS_TIMER_SER) ##0 !rd_en ##1 (!wr_en && rd_en && addr == OFS_TIMER_SER)
            |=> rd_data == $past(wr_data, 2);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("register did not read back the written value");

    property p_rd_idle;
        @(posedge core_clk) disable iff (rst)
        !rd_en |=> rd_data == RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data present without a read");
endmodule

// ==== req_sources.sv ====
// far-side model of the request sources, driven from one pending vector
`timescale 1ns/1ps
module req_sources (
    input  wire logic [prio_pkg::NUM_SRC-1:0] pending,
    output logic      [prio_pkg::NUM_EXT-1:0] irq_pin_n,
    output logic      [prio_pkg::NUM_DMA-1:0] dma_req,
    output logic      [prio_pkg::NUM_TMR-1:0] timer_req,
    output logic      [prio_pkg::NUM_SER-1:0] serial_req,
    output logic                              parity_req,
    output logic                              adc_req,
    output logic                              watchdog_req,
    output logic                              refresh_req
);
    import prio_pkg::*;
    // ********************
    // request lines
    // ********************
    // pins are active low; an idle line sits at its pull-up level
    assign irq_pin_n    = ~pending[SRC_DMA-1:0];
    assign dma_req      = pending[SRC_TMR-1:SRC_DMA];
    assign timer_req    = pending[SRC_SER-1:SRC_TMR];
    assign serial_req   = pending[SRC_PAR-1:SRC_SER];
    assign parity_req   = pending[SRC_PAR];
    assign adc_req      = pending[SRC_ADC];
    assign watchdog_req = pending[SRC_WDT];
    assign refresh_req  = pending[SRC_REF];
endmodule

// ==== tb_top.sv ====
// self-checking bench for the interrupt priority level bank
`timescale 1ns/1ps
module tb_top;
    import prio_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst      = 1'b1;
    logic [ADDR_W-1:0]  addr     = '0;
    logic [DATA_W-1:0]  wr_data  = '0;
    logic               wr_en    = 1'b0;
    logic               rd_en    = 1'b0;
    logic [NUM_SRC-1:0] pending  = '0;
    logic [DATA_W-1:0]  rd_data;
    logic [NUM_EXT-1:0] irq_pin_n;
    logic [NUM_DMA-1:0] dma_req;
    logic [NUM_TMR-1:0] timer_req;
    logic [NUM_SER-1:0] serial_req;
    logic               parity_req, adc_req, watchdog_req, refresh_req, irq_req;
    logic [LVL_W-1:0]   irq_level;
    logic [SRC_W-1:0]   irq_source;
    logic [DATA_W-1:0]  img [5];
    logic [ADDR_W-1:0]  ofs [5] = '{OFS_LINE_LOW, OFS_LINE_HIGH, OFS_DMA_TIMER,
                                    OFS_TIMER_SER, OFS_SER_BUS_WD};
    int                 errors = 0;
    int                 checks = 0;
    int                 seed   = 44412;

    always #5 core_clk = ~core_clk;

    req_sources u_req_sources (.pending(pending), .irq_pin_n(irq_pin_n), .dma_req(dma_req),
        .timer_req(timer_req), .serial_req(serial_req), .parity_req(parity_req),
        .adc_req(adc_req), .watchdog_req(watchdog_req), .refresh_req(refresh_req));

    interrupt_priority_levels u_interrupt_priority_levels (.core_clk(core_clk), .rst(rst),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .irq_pin_n(irq_pin_n), .dma_req(dma_req), .timer_req(timer_req),
        .serial_req(serial_req), .parity_req(parity_req), .adc_req(adc_req),
        .watchdog_req(watchdog_req), .refresh_req(refresh_req), .irq_req(irq_req),
        .irq_level(irq_level), .irq_source(irq_source));

    // ********************
    // expectation helpers
    // ********************
    // register index times four plus nibble index of a source's level field
    function automatic int fld(input int s);
        case (s)
            0, 1, 2, 3: return 3 - s;
            4, 5, 6, 7: return 11 - s;
            8, 9:       return 11;
            10, 11:     return 10;
            12:         return 9;
            13:         return 8;
            14, 15, 16: return 29 - s;
            17:         return 12;
            18:         return 19;
            19, 20:     return 18;
            default:    return 17;
        endcase
    endfunction

    function automatic logic [15:0] exp_sel(input logic [NUM_SRC-1:0] p);
        logic [3:0] bl;
        logic [3:0] l;
        int         bs;
        bl = 4'h0;
        bs = 0;
        // strict compare keeps the lower source number on a tie
        for (int s = 0; s < NUM_SRC; s++) begin
            l = img[fld(s) / 4][(fld(s) % 4) * 4 +: 4];
            if (p[s] && l > bl) begin
                bl = l;
                bs = s;
            end
        end
        return {6'h00, bl != 4'h0, bl, 5'(bs)};
    endfunction

    function automatic logic [15:0] outw();
        return {6'h00, irq_req, irq_level, irq_source};
    endfunction

    // ********************
    // bus and check tasks
    // ********************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // write strobe followed at once by a read strobe to the same word
    task automatic wr_rd(input  logic [ADDR_W-1:0] a,
                         input  logic [DATA_W-1:0] wd,
                         output logic [DATA_W-1:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= wd;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        @(posedge core_clk);
        rd_en   <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic rd_all();
        logic [DATA_W-1:0] d;
        for (int r = 0; r < 5; r++) begin
            rd(ofs[r], d);
            chk(d, img[r]);
        end
    endtask

    // outputs follow pins three edges later, so four edges always settle
    task automatic set_pend(input logic [NUM_SRC-1:0] p);
        @(posedge core_clk);
        pending <= p;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("summary: %0d checks, %0d mismatches", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 16'h0000, 16'hFFFF);
        complete_run();
    end

    initial begin
        logic [DATA_W-1:0] d;
        logic [3:0]        lv;
        int                f;
        for (int r = 0; r < 5; r++) img[r] = RST_LEVELS;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd_all();
        chk(outw(), 16'h0000);
        // unmapped word is refused; read data lasts one cycle only
        wr(28'h5FFFF8E, 16'hFFFF);
        rd(28'h5FFFF8E, d);
        chk(d, RD_IDLE);
        img[3] = 16'($random(seed));
        wr_rd(OFS_TIMER_SER, img[3], d);
        chk(d, img[3]);
        rd_all();
        @(posedge core_clk);
        #1 chk(rd_data, RD_IDLE);
        $display("test reset and map done");
        for (int s = 0; s < NUM_SRC; s++) begin
            f  = fld(s);
            lv = 4'($random(seed));
            if (lv == 4'h0) lv = 4'h9;
            img[f / 4] = 16'(lv) << (4 * (f % 4));
            wr(ofs[f / 4], img[f / 4]);
            set_pend(NUM_SRC'(1) << s);
            chk(outw(), exp_sel(pending));
            img[f / 4] = RST_LEVELS;
            wr(ofs[f / 4], img[f / 4]);
            set_pend(pending);
            chk(outw(), exp_sel(pending));
        end
        $display("test field per source done");
        for (int i = 0; i < 30; i++) begin
            for (int r = 0; r < 5; r++) begin
                img[r] = (i == 0) ? 16'hFFFF : 16'($random(seed));
                wr(ofs[r], img[r]);
            end
            set_pend((i == 0) ? {NUM_SRC{1'b1}} : NUM_SRC'($random(seed)));
            chk(outw(), exp_sel(pending));
        end
        rd_all();
        $display("test random selection done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int r = 0; r < 5; r++) img[r] = RST_LEVELS;
        #1 chk(outw(), 16'h0000);
        rd_all();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
